// *** hdl/conv_clk_div.sv ***
// conversion clock divider: tick ratio is divider plus one, conv_clk ratio twice that
`timescale 1ns/10ps
module conv_clk_div #(
  parameter int DIV_W = 5
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] divider,
  output logic                  sar_tick,
  output logic                  conv_clk
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             next_tick;
  logic             next_clk;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("conv_clk_div: DIV_W out of range");
  end

  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    next_clk   = conv_clk;
    if (src_tick) begin
      if (count >= divider) begin
        next_count = '0;
        next_tick  = 1'b1;
        next_clk   = ~conv_clk;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count    <= '0;
      sar_tick <= 1'b0;
      conv_clk <= 1'b0;
    end else begin
      count    <= next_count;
      sar_tick <= next_tick;
      conv_clk <= next_clk;
    end
  end
endmodule

// *** hdl/edge_sync.sv ***
// two-stage synchroniser with registered rise and fall pulses
`timescale 1ns/10ps
module edge_sync (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic stable;
  logic last;
  logic next_rise;
  logic next_fall;

  always_comb begin
    next_rise = stable & ~last;
    next_fall = ~stable & last;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      meta   <= din;
      stable <= meta;
      last   <= stable;
      rise   <= next_rise;
      fall   <= next_fall;
    end
  end
endmodule

// *** hdl/sar_adc_ctrl.sv ***
// conversion control of the successive-approximation converter, apb register slave
// Function
// - justify 000 right-aligns result, 100 left-aligns ten-bit code
// - single conversions give unsigned ten-bit code, zero to 1023/1024 scale
// - result bits outside the formatted value read zero
// - repeat above one: result holds the sum, updated after final conversion
// - repeat count selects 1, 4, 8, 16, 32 or 64 samples
// - 16-bit accumulator shifted right by 0 to 3 before result
// - conversion clock: system clock or low-power oscillator, divided
// - start source: busy write, timer 0, 2, 3, external rising edge
// - busy reads one during conversion, zero when it finishes
// - busy falling at the end of a series sets done flag and interrupt request when enabled
// - result registers valid whenever done flag is set
// - timers 2 and 3: low-byte overflow in 8-bit, high-byte in 16-bit
// - sync option holds triggered conversion until next dc-dc pulse
// - sync option makes dc-dc clock the conversion clock
// - invert bit inverts dc-dc supplied conversion clock
// - throughput up to 300 ksps ten-bit
// - burst powers up, samples, accumulates, shuts down unattended
// - burst: one trigger runs repeat-count conversions; flag after all
// - low-power tracking adds 3 conversion clocks before each conversion
// - burst: enable zero powers down after burst, one stays on
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
module sar_adc_ctrl import sar_adc_pkg::*; #(
  parameter int          ACC_W          = 16,
  parameter int          DATA_W         = 10,
  parameter logic [7:0]  POWER_UP_TICKS = `POWER_UP_TICKS
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              timer0_ovf,
  input  wire logic              timer2_low_ovf,
  input  wire logic              timer2_high_ovf,
  input  wire logic              timer3_low_ovf,
  input  wire logic              timer3_high_ovf,
  input  wire logic              external_start_in,
  input  wire logic              lp_osc_in,
  input  wire logic              dcdc_clk_in,
  input  wire logic              sar_done,
  input  wire logic [DATA_W-1:0] sar_data,
  output logic                   sar_start,
  output logic                   sar_power,
  output logic                   conversion_clock,
  output logic                   conv_irq
);
  if (ACC_W != 16 || DATA_W != 10) begin : g_chk
    $error("sar_adc_ctrl: only a 16-bit accumulator of 10-bit codes is served");
  end

  converter_control_t   ctl;
  converter_control_t   next_ctl;
  converter_config_t    cfg;
  converter_config_t    next_cfg;
  accumulator_control_t accc;
  accumulator_control_t next_accc;
  logic                 done;
  logic                 next_done;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 next_irq;

  conv_state_t          st;
  conv_state_t          next_st;
  logic [7:0]           cnt;
  logic [7:0]           next_cnt;
  logic [6:0]           samples;
  logic [6:0]           next_samples;
  logic [ACC_W-1:0]     acc;
  logic [ACC_W-1:0]     next_acc;
  logic [15:0]          result;
  logic [15:0]          next_result;
  logic                 next_start;
  logic                 next_power;
  logic                 series_end;

  logic                 ext_rise;
  logic                 lp_rise;
  logic                 dc_rise;
  logic                 dc_fall;
  logic                 src_tick;
  logic                 sar_tick;
  logic                 dc_edge;
  logic                 busy;
  logic                 wr_en;
  logic                 sw_start;
  logic                 trigger;
  logic [6:0]           target;
  logic [ACC_W-1:0]     sum;
  logic [15:0]          shaped;

  edge_sync u_ext (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (external_start_in),
    .rise    (ext_rise),
    .fall    ()
  );

  edge_sync u_lposc (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (lp_osc_in),
    .rise    (lp_rise),
    .fall    ()
  );

  edge_sync u_dcdc (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (dcdc_clk_in),
    .rise    (dc_rise),
    .fall    (dc_fall)
  );

  conv_clk_div #(
    .DIV_W (5)
  ) u_div (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .src_tick (src_tick),
    .divider  (cfg.conv_clock_divider),
    .sar_tick (sar_tick),
    .conv_clk (conversion_clock)
  );

  // clock source and trigger selection
  always_comb begin
    dc_edge  = cfg.sync_clock_invert ? dc_fall : dc_rise;
    if (cfg.sync_enable) begin
      src_tick = dc_edge;
    end else if (ctl.burst_enable) begin
      src_tick = lp_rise;
    end else begin
      src_tick = 1'b1;
    end
    busy     = (st != ST_IDLE);
    wr_en    = psel & penable & pready & pwrite;
    sw_start = wr_en & (paddr == `OFS_CONTROL) & pwdata[`CTL_BUSY];
    case (ctl.start_source_sel)
      3'h0:    trigger = sw_start;
      3'h1:    trigger = timer0_ovf;
      3'h2:    trigger = cfg.timer2_16bit ? timer2_high_ovf : timer2_low_ovf;
      3'h3:    trigger = cfg.timer3_16bit ? timer3_high_ovf : timer3_low_ovf;
      3'h4:    trigger = ext_rise;
      default: trigger = 1'b0;
    endcase
    case (accc.repeat_count_sel)
      3'h0:    target = 7'h01;
      3'h1:    target = 7'h04;
      3'h2:    target = 7'h08;
      3'h3:    target = 7'h10;
      3'h4:    target = 7'h20;
      default: target = 7'h40;
    endcase
  end

  // conversion sequencer
  always_comb begin
    next_st      = st;
    next_cnt     = cnt;
    next_samples = samples;
    next_acc     = acc;
    next_result  = result;
    next_start   = 1'b0;
    series_end   = 1'b0;
    sum          = (samples == 7'h00) ? ACC_W'(sar_data) : acc + ACC_W'(sar_data);
    if (accc.justify_shift_sel[2]) begin
      shaped = {sum[DATA_W-1:0], 6'h00};
    end else begin
      shaped = sum >> accc.justify_shift_sel[1:0];
    end
    // without burst the core must already be enabled to convert
    next_power   = ctl.converter_enable | (ctl.burst_enable & busy);
    case (st)
      ST_IDLE: begin
        if (trigger && (ctl.converter_enable || ctl.burst_enable)) begin
          next_cnt = 8'h00;
          if (ctl.burst_enable && !ctl.converter_enable) begin
            next_st    = ST_POWERUP;
            next_power = 1'b1;
          end else begin
            next_st = ST_SYNC_WAIT;
          end
        end
      end
      ST_POWERUP: begin
        if (sar_tick) begin
          next_cnt = cnt + 8'h01;
          if (next_cnt >= POWER_UP_TICKS) begin
            next_st  = ST_SYNC_WAIT;
            next_cnt = 8'h00;
          end
        end
      end
      ST_SYNC_WAIT: begin
        if (!cfg.sync_enable || dc_edge) begin
          next_cnt = 8'h00;
          if (ctl.low_power_track_sel) begin
            next_st = ST_TRACK;
          end else begin
            next_st    = ST_CONVERT;
            next_start = 1'b1;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          next_cnt = cnt + 8'h01;
          if (next_cnt >= `TRACK_TICKS) begin
            next_st    = ST_CONVERT;
            next_start = 1'b1;
          end
        end
      end
      ST_CONVERT: begin
        // the core paces each conversion; this state only waits for sar_done, bounding throughput
        if (sar_done) begin
          next_acc     = sum;
          next_samples = samples + 7'h01;
          if (next_samples >= target) begin
            series_end   = 1'b1;
            next_result  = shaped;
            next_samples = 7'h00;
            next_st      = ST_IDLE;
          end else if (ctl.burst_enable) begin
            next_st = ST_SYNC_WAIT;
          end else begin
            next_st = ST_IDLE;
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st        <= ST_IDLE;
      cnt       <= 8'h00;
      samples   <= 7'h00;
      acc       <= '0;
      result    <= 16'h0000;
      sar_start <= 1'b0;
      sar_power <= 1'b0;
    end else begin
      st        <= next_st;
      cnt       <= next_cnt;
      samples   <= next_samples;
      acc       <= next_acc;
      result    <= next_result;
      sar_start <= next_start;
      sar_power <= next_power;
    end
  end

  // register file; read data is captured in the setup cycle, no wait state
  always_comb begin
    next_ctl     = ctl;
    next_cfg     = cfg;
    next_accc    = accc;
    next_done    = done;
    next_pready  = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (wr_en) begin
      case (paddr)
        `OFS_CONTROL: begin
          next_ctl.start_source_sel    = pwdata[`CTL_START_LSB +: 3];
          next_ctl.low_power_track_sel = pwdata[`CTL_TRACK];
          next_ctl.burst_enable        = pwdata[`CTL_BURST];
          next_ctl.converter_enable    = pwdata[`CTL_ENABLE];
          next_ctl.irq_enable          = pwdata[`CTL_IRQ_EN];
          next_done                    = done & pwdata[`CTL_DONE];
        end
        `OFS_CONFIG: begin
          next_cfg.conv_clock_divider = pwdata[`CFG_DIV_LSB +: 5];
          next_cfg.sync_enable        = pwdata[`CFG_SYNC];
          next_cfg.sync_clock_invert  = pwdata[`CFG_INVERT];
          next_cfg.timer2_16bit       = pwdata[`CFG_T2_16BIT];
          next_cfg.timer3_16bit       = pwdata[`CFG_T3_16BIT];
        end
        `OFS_ACCUM: begin
          next_accc.repeat_count_sel  = pwdata[`ACC_RPT_LSB +: 3];
          next_accc.justify_shift_sel = pwdata[`ACC_SJST_LSB +: 3];
        end
        default: next_done = done;
      endcase
    end
    // a completion in the clearing cycle wins over the clear
    if (series_end) begin
      next_done = 1'b1;
    end
    if (psel && !penable) begin
      case (paddr)
        `OFS_CONTROL: begin
          next_prdata[`CTL_START_LSB +: 3] = ctl.start_source_sel;
          next_prdata[`CTL_BUSY]           = busy;
          next_prdata[`CTL_DONE]           = done;
          next_prdata[`CTL_TRACK]          = ctl.low_power_track_sel;
          next_prdata[`CTL_BURST]          = ctl.burst_enable;
          next_prdata[`CTL_ENABLE]         = ctl.converter_enable;
          next_prdata[`CTL_IRQ_EN]         = ctl.irq_enable;
        end
        `OFS_CONFIG: begin
          next_prdata[`CFG_DIV_LSB +: 5] = cfg.conv_clock_divider;
          next_prdata[`CFG_SYNC]         = cfg.sync_enable;
          next_prdata[`CFG_INVERT]       = cfg.sync_clock_invert;
          next_prdata[`CFG_T2_16BIT]     = cfg.timer2_16bit;
          next_prdata[`CFG_T3_16BIT]     = cfg.timer3_16bit;
        end
        `OFS_ACCUM: begin
          next_prdata[`ACC_RPT_LSB +: 3]  = accc.repeat_count_sel;
          next_prdata[`ACC_SJST_LSB +: 3] = accc.justify_shift_sel;
        end
        `OFS_RESULT: next_prdata[15:0] = result;
        default:     next_pslverr      = 1'b1;
      endcase
    end
    next_irq = next_done & next_ctl.irq_enable;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl      <= '{irq_enable: 1'b0, converter_enable: 1'b0, burst_enable: 1'b0,
                    low_power_track_sel: 1'b0, start_source_sel: `RST_START_SEL};
      cfg      <= '{timer3_16bit: 1'b0, timer2_16bit: 1'b0, sync_clock_invert: 1'b0,
                    sync_enable: 1'b0, conv_clock_divider: `RST_DIVIDER};
      accc     <= '{justify_shift_sel: `RST_JUSTIFY, repeat_count_sel: `RST_REPEAT};
      done     <= 1'b0;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      ctl      <= next_ctl;
      cfg      <= next_cfg;
      accc     <= next_accc;
      done     <= next_done;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      conv_irq <= next_irq;
    end
  end
endmodule

// *** hdl/sar_adc_defines.svh ***
// offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define OFS_CONTROL      8'h00
`define OFS_CONFIG       8'h04
`define OFS_ACCUM        8'h08
`define OFS_RESULT       8'h0C
`define CTL_START_LSB    0
`define CTL_BUSY         3
`define CTL_DONE         4
`define CTL_TRACK        5
`define CTL_BURST        6
`define CTL_ENABLE       7
`define CTL_IRQ_EN       8
`define CFG_DIV_LSB      0
`define CFG_SYNC         5
`define CFG_INVERT       6
`define CFG_T2_16BIT     7
`define CFG_T3_16BIT     8
`define ACC_RPT_LSB      0
`define ACC_SJST_LSB     3
`define RST_DIVIDER      5'h1F
`define RST_START_SEL    3'h0
`define RST_REPEAT       3'h0
`define RST_JUSTIFY      3'h0
`define TRACK_TICKS      8'h03
`define POWER_UP_TICKS   8'h10
`endif

// *** hdl/sar_adc_pkg.sv ***
// types shared by the converter control files
package sar_adc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POWERUP,
    ST_SYNC_WAIT,
    ST_TRACK,
    ST_CONVERT
  } conv_state_t;

  typedef struct packed {
    logic       irq_enable;
    logic       converter_enable;
    logic       burst_enable;
    logic       low_power_track_sel;
    logic [2:0] start_source_sel;
  } converter_control_t;

  typedef struct packed {
    logic       timer3_16bit;
    logic       timer2_16bit;
    logic       sync_clock_invert;
    logic       sync_enable;
    logic [4:0] conv_clock_divider;
  } converter_config_t;

  typedef struct packed {
    logic [2:0] justify_shift_sel;
    logic [2:0] repeat_count_sel;
  } accumulator_control_t;
endpackage

// *** tb/sar_adc_ctrl_sva.sv ***
// port assertions of the converter control
`timescale 1ns/10ps
module sar_adc_ctrl_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sar_done,
  input wire logic        sar_start,
  input wire logic        sar_power,
  input wire logic        conv_irq
);
  logic flight;
  logic next_flight;
  logic wr_acc;
  assign next_flight = sar_start | (flight & ~sar_done);
  assign wr_acc      = psel & penable & pready & pwrite;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) flight <= 1'b0;
    else flight <= next_flight;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_map: assert property (pready |-> pslverr == (paddr > 8'h0C || paddr[1:0] != 2'h0))
    else $error("error flag does not match decode");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_res_upper: assert property (pready && !pwrite && paddr == 8'h0C |-> prdata[31:16] == 16'h0)
    else $error("result upper bits not zero");
  a_start_pulse: assert property (sar_start |=> !sar_start)
    else $error("start longer than one cycle");
  a_start_power: assert property (sar_start |-> sar_power)
    else $error("start while unpowered");
  a_one_flight: assert property (sar_start |-> !flight)
    else $error("start while a conversion runs");
  a_irq_cause: assert property ($rose(conv_irq) |-> $past(sar_done)
    || $past(sar_done, 2) || $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt rose without cause");
  c_done: cover property (sar_done);
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(conv_irq));
endmodule
bind sar_adc_ctrl sar_adc_ctrl_sva chk_i (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .sar_done, .sar_start, .sar_power, .conv_irq);

// *** tb/sar_adc_ctrl_tb_top.sv ***
// self-checking bench of the converter control
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
module sar_adc_ctrl_tb_top;
  logic        sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        dc = 1'b0, lp = 1'b0, pready, pslverr, e, ccq;
  logic        sar_done, sar_start, sar_power, conversion_clock, conv_irq;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, old;
  logic [5:0]  trig = 6'h00;
  logic [9:0]  sar_data, code = 10'h3FF;
  logic [15:0] rnd = 16'h0007, exp_acc = 16'h0000, s;
  logic [1:0]  pick = 2'h1;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, nst = 0, nd = 0, tst = 0, cct = 0;
  int          t0, n, c0;
  int          src[6] = '{1, 2, 2, 3, 3, 4};
  int          bad[6] = '{1, 2, 1, 4, 3, 0};
  int          cfg[6] = '{0, 0, 'h80, 0, 'h100, 0};

  sar_adc_ctrl #(.POWER_UP_TICKS(8'h02)) dut (.sys_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer0_ovf(trig[0]),
    .timer2_low_ovf(trig[1]), .timer2_high_ovf(trig[2]), .timer3_low_ovf(trig[3]),
    .timer3_high_ovf(trig[4]), .external_start_in(trig[5]), .lp_osc_in(lp),
    .dcdc_clk_in(dc), .sar_done, .sar_data, .sar_start, .sar_power, .conversion_clock,
    .conv_irq);
  sar_core_model core (.sys_clk, .arst_n, .sar_start, .code_in(code),
    .wait_in(4'h4 + {1'b0, rnd[2:0]}), .sar_done, .sar_data);

  always #20 sys_clk = ~sys_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // left justify keeps only the low ten bits of the sum
  function automatic logic [31:0] fmt(input logic [15:0] v, input logic [2:0] j);
    return j[2] ? {16'h0, v[9:0], 6'h00} : {16'h0, v >> j[1:0]};
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // idle edge at the end keeps each signal to one assignment per time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic wdone;
    do apb(1'b0, 8'h00, 32'h0); while (r[4] !== 1'b1);
  endtask
  task automatic pulse(input int i);
    trig <= 6'h01 << i;
    @(posedge sys_clk);
    trig <= 6'h00;
    @(posedge sys_clk);
  endtask
  task automatic series(input logic [31:0] ctl, input logic [5:0] acc, input int how);
    apb(1'b1, 8'h08, {26'h0, acc});
    s = exp_acc;
    n = nst;
    // enable first: a start in the same write meets the old enable and source
    apb(1'b1, 8'h00, ctl);
    if (how > 5) begin
      apb(1'b1, 8'h00, ctl | 32'h8);
      t0 = cyc;
      apb(1'b0, 8'h00, 32'h0);
      chk(r[3], 1'b1);
    end else begin
      pulse(how);
    end
    wdone;
    rd(8'h0C, fmt(exp_acc - s, acc[5:3]));
    chk(nst - n, acc[2:0] == 0 ? 1 : acc[2:0] > 4 ? 64 : 2 << acc[2:0]);
    chk(sar_power, ctl[7]);
    chk(conv_irq, ctl[8]);
    apb(1'b1, 8'h00, ctl);
    @(posedge sys_clk);
    chk(conv_irq, 1'b0);
    rd(8'h00, ctl);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lp <= (cyc % 3 == 0) ? ~lp : lp;
    ccq <= conversion_clock;
    if (conversion_clock !== ccq) cct <= cct + 1;
    rnd <= lfsr(rnd);
    if (sar_start) begin
      nst <= nst + 1;
      tst <= cyc;
    end
    if (sar_done) begin
      nd <= nd + 1;
      exp_acc <= exp_acc + {6'h00, sar_data};
      code <= pick == 2'h1 ? 10'h3FF : pick == 2'h2 ? 10'h000 : rnd[9:0];
    end
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up;
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'h04, {27'h0, `RST_DIVIDER});
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk(e, 1'b1);
    apb(1'b0, 8'h11, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("registers finished");
    apb(1'b1, 8'h04, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pick <= i < 2 ? 2'(i + 1) : 2'h0;
      series(i[1] ? 32'h180 : 32'h80, {i[0], 5'h00}, 6);
    end
    $display("single conversions finished");
    for (int k = 1; k < 8; k++) series(k[0] ? 32'hC0 : 32'h40, 6'(((k - 1) % 4) * 8 + k), 6);
    $display("bursts finished");
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'h81);
    s = exp_acc;
    apb(1'b0, 8'h0C, 32'h0);
    old = r;
    for (int k = 0; k < 4; k++) begin
      n = nd;
      pulse(0);
      while (nd == n) @(posedge sys_clk);
      if (k < 3) begin
        rd(8'h0C, old);
        apb(1'b0, 8'h00, 32'h0);
        chk(r[4], 1'b0);
      end
    end
    wdone;
    rd(8'h0C, fmt(exp_acc - s, 3'h0));
    apb(1'b1, 8'h00, 32'h81);
    $display("timed series finished");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h04, cfg[i]);
      apb(1'b1, 8'h00, 32'h80 | src[i]);
      n = nst;
      pulse(bad[i]);
      repeat (10) @(posedge sys_clk);
      chk(nst - n, 0);
      series(32'h80 | src[i], 6'h00, i);
    end
    $display("start sources finished");
    apb(1'b1, 8'h04, 32'h0);
    series(32'h80, 6'h00, 6);
    c0 = tst - t0;
    series(32'hA0, 6'h00, 6);
    chk(tst - t0 - c0, 3);
    for (int inv = 0; inv < 2; inv++) begin
      dc <= !inv[0];
      apb(1'b1, 8'h04, 32'h20 | (inv << 6));
      // let the dc level change and the last free-running toggle drain first
      repeat (4) @(posedge sys_clk);
      c0 = cct;
      repeat (20) @(posedge sys_clk);
      chk(cct - c0, 0);
      n = nst;
      apb(1'b1, 8'h00, 32'h88);
      dc <= inv[0];
      repeat (10) @(posedge sys_clk);
      chk(nst - n, 0);
      dc <= !inv[0];
      wdone;
      chk(nst - n, 1);
      apb(1'b1, 8'h00, 32'h80);
    end
    $display("sync finished");
    apb(1'b1, 8'h04, 32'h3);
    // window starts once the new divide ratio runs steadily
    repeat (4) @(posedge sys_clk);
    c0 = cct;
    repeat (40) @(posedge sys_clk);
    chk(cct - c0, 10);
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h04, 32'h0);
    repeat (4) @(posedge sys_clk);
    c0 = cct;
    repeat (60) @(posedge sys_clk);
    chk(cct - c0, 10);
    $display("clocks finished");
    wrap_up;
  end
endmodule

// *** tb/sar_core_model.sv ***
// behavioural model of the analog converter core
`timescale 1ns/10ps
module sar_core_model (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       sar_start,
  input  wire logic [9:0] code_in,
  input  wire logic [3:0] wait_in,
  output logic            sar_done,
  output logic [9:0]      sar_data
);
  logic [3:0] cnt;
  logic [9:0] hold;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt      <= 4'h0;
      hold     <= 10'h000;
      sar_done <= 1'b0;
      sar_data <= 10'h000;
    end else begin
      sar_done <= 1'b0;
      // data is only meaningful in the done cycle, so it churns otherwise
      sar_data <= ~sar_data;
      if (sar_start) begin
        cnt  <= wait_in;
        hold <= code_in;
      end else if (cnt == 4'h1) begin
        sar_done <= 1'b1;
        sar_data <= hold;
        cnt      <= 4'h0;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
